// ### vfd_defines.svh
// constants for the display scan controller: offsets, fields, resets, timing
// assumes a 50 MHz pclk and a 32-bit APB slave window of 128 bytes
`ifndef VFD_DEFINES_SVH
`define VFD_DEFINES_SVH

// ****************************************************************
// register map (byte addresses)
// ****************************************************************
`define VFD_OFS_BOUNDARY 8'h00
`define VFD_OFS_SEGMENT 8'h04
`define VFD_OFS_DIGIT 8'h08
`define VFD_OFS_STATUS 8'h0c
`define VFD_RAM_BASE 8'h40
`define VFD_RAM_WORDS 16

// ****************************************************************
// fields
// ****************************************************************
`define VFD_BIT_RUN 7
`define VFD_BIT_LAMP 6
`define VFD_BIT_SPARE 4
`define VFD_BIT_PFS 7
`define VFD_BIT_KSE 6
`define VFD_FIXED_ONE 8'h20
`define VFD_SHARED_PINS 8
`define VFD_SEGS 24
`define VFD_DIGITS 16
`define VFD_LAST_DIGIT 5'h0f

// ****************************************************************
// reset values
// ****************************************************************
`define VFD_RST_BOUNDARY 8'h20
`define VFD_RST_SEGMENT 8'h20
`define VFD_RST_DIGIT 8'h00

// ****************************************************************
// timing
// ****************************************************************
`define VFD_CLK_NS 20
`define VFD_SLOT_NS 1000
`define VFD_SLOT_CYC ((`VFD_SLOT_NS + `VFD_CLK_NS - 1) / `VFD_CLK_NS)

`endif

// ### vfd_pkg.sv
// types shared by the display scan controller
// assumes vfd_defines.svh is compiled alongside
package vfd_pkg;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_DIGIT = 3'b010,
      ST_KEY = 3'b100
   } scan_state_t;

   typedef enum logic [4:0] {
      AK_BOUNDARY = 5'b00001,
      AK_SEGMENT = 5'b00010,
      AK_DIGIT = 5'b00100,
      AK_STATUS = 5'b01000,
      AK_RAM = 5'b10000
   } addr_kind_t;

endpackage

// ### vfd_scan_ctrl.sv
// display scan controller: APB registers, display RAM, digit scan, pins
// assumes port logic outside takes the pins while port_mode is high
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "vfd_defines.svh"

module vfd_scan_ctrl
   import vfd_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // display pins
   output logic [15:8] grid_pin,
   output logic [23:8] anode_pin,
   output logic [7:0] shared_pin,
   output logic [7:0] shared_is_anode,
   output logic port_mode,
   // key scan slot start, one cycle
   output logic scan_irq_flag
);

   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic shared_anode(input logic [2:0] k,
                                         input logic [3:0] split);
      shared_anode = split[3] | ({1'b0, k} < split);
   endfunction

   function automatic addr_kind_t decode(input logic [7:0] a,
                                         output logic hit);
      hit = 1'b1;
      decode = AK_STATUS;
      if (a == `VFD_OFS_BOUNDARY) begin
         decode = AK_BOUNDARY;
      end else if (a == `VFD_OFS_SEGMENT) begin
         decode = AK_SEGMENT;
      end else if (a == `VFD_OFS_DIGIT) begin
         decode = AK_DIGIT;
      end else if (a == `VFD_OFS_STATUS) begin
         decode = AK_STATUS;
      end else if (a[7:6] == `VFD_RAM_BASE >> 6 && a[1:0] == 2'h0) begin
         decode = AK_RAM;
      end else begin
         hit = 1'b0;
      end
   endfunction

   // ****************************************************************
   // register and bus state
   // ****************************************************************
   logic [7:0] boundary_q, boundary_d;
   logic [7:0] segment_q, segment_d;
   logic [7:0] digit_q, digit_d;
   logic [31:0] ram_q [`VFD_RAM_WORDS];
   logic [31:0] ram_d [`VFD_RAM_WORDS];
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;
   logic ctrl_wr;

   scan_state_t st_q, st_d;
   logic [3:0] dig_q, dig_d;
   logic [5:0] tmr_q, tmr_d;
   logic irq_q, irq_d;

   logic [15:8] grid_q, grid_d;
   logic [23:8] anode_q, anode_d;
   logic [7:0] shared_q, shared_d;
   logic [7:0] role_q, role_d;
   logic port_q, port_d;

   // ****************************************************************
   // apb slave and registers
   // ****************************************************************
   // read data is prepared in the setup cycle, so every access is one cycle
   always_comb begin
      addr_kind_t kind;
      logic hit;
      logic [3:0] w;
      kind = decode(paddr, hit);
      w = paddr[5:2];
      boundary_d = boundary_q;
      segment_d = segment_q;
      digit_d = digit_q;
      ram_d = ram_q;
      prdata_d = prdata_q;
      pready_d = 1'b0;
      pslverr_d = 1'b0;
      ctrl_wr = 1'b0;
      if (psel && !penable) begin
         pready_d = 1'b1;
         pslverr_d = !hit || (pwrite && kind == AK_STATUS);
         prdata_d = 32'h0000_0000;
         case (kind)
            AK_BOUNDARY: prdata_d[7:0] = boundary_q | `VFD_FIXED_ONE;
            AK_SEGMENT: begin
               prdata_d[7:0] = segment_q | `VFD_FIXED_ONE;
               if (st_q == ST_KEY) begin
                  prdata_d[`VFD_BIT_PFS] = 1'b0;
               end
            end
            AK_DIGIT: prdata_d[7:0] = digit_q;
            AK_STATUS: prdata_d[7:0] = {1'b0, st_q, dig_q};
            AK_RAM: prdata_d = ram_q[w];
            default: prdata_d = 32'h0000_0000;
         endcase
         if (!hit) begin
            prdata_d = 32'h0000_0000;
         end
      end
      if (psel && penable && pready_q && pwrite && !pslverr_q) begin
         case (kind)
            AK_BOUNDARY: begin
               if (pstrb[0]) begin
                  // bit 5 is never stored, bit 4 is spare storage
                  boundary_d = pwdata[7:0] & ~`VFD_FIXED_ONE;
                  ctrl_wr = 1'b1;
               end
            end
            AK_SEGMENT: begin
               if (pstrb[0]) begin
                  segment_d = pwdata[7:0] & ~`VFD_FIXED_ONE;
                  ctrl_wr = 1'b1;
               end
            end
            AK_DIGIT: begin
               if (pstrb[0]) begin
                  digit_d = pwdata[7:0];
                  ctrl_wr = 1'b1;
               end
            end
            AK_RAM: begin
               for (int b = 0; b < 4; b++) begin
                  if (pstrb[b]) begin
                     ram_d[w][b*8 +: 8] = pwdata[b*8 +: 8];
                  end
               end
            end
            default: ctrl_wr = 1'b0;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         boundary_q <= `VFD_RST_BOUNDARY & ~`VFD_FIXED_ONE;
         segment_q <= `VFD_RST_SEGMENT & ~`VFD_FIXED_ONE;
         digit_q <= `VFD_RST_DIGIT;
         for (int i = 0; i < `VFD_RAM_WORDS; i++) begin
            ram_q[i] <= 32'h0000_0000;
         end
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         boundary_q <= boundary_d;
         segment_q <= segment_d;
         digit_q <= digit_d;
         ram_q <= ram_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   // ****************************************************************
   // scan timing
   // ****************************************************************
   logic run;
   logic keyscan_slot_en;
   logic [4:0] first_dig;
   logic [4:0] last_dig;
   logic any_dig;
   logic slot_end;

   always_comb begin
      run = boundary_q[`VFD_BIT_RUN];
      keyscan_slot_en = segment_q[`VFD_BIT_KSE];
      // digits start at the split point and end at digit 15 minus the digit register
      first_dig = boundary_q[3] ? 5'h08 : {2'b00, boundary_q[2:0]};
      last_dig = `VFD_LAST_DIGIT - {1'b0, digit_q[3:0]};
      any_dig = first_dig <= last_dig;
      slot_end = tmr_q == 6'(`VFD_SLOT_CYC - 1);
      st_d = st_q;
      dig_d = dig_q;
      tmr_d = tmr_q + 6'h01;
      irq_d = 1'b0;
      case (st_q)
         ST_IDLE: begin
            tmr_d = 6'h00;
            if (any_dig) begin
               st_d = ST_DIGIT;
               dig_d = first_dig[3:0];
            end else if (keyscan_slot_en) begin
               st_d = ST_KEY;
               irq_d = 1'b1;
            end
         end
         ST_DIGIT: begin
            if (slot_end) begin
               tmr_d = 6'h00;
               if ({1'b0, dig_q} >= last_dig) begin
                  dig_d = first_dig[3:0];
                  if (keyscan_slot_en) begin
                     st_d = ST_KEY;
                     irq_d = 1'b1;
                  end
               end else begin
                  dig_d = dig_q + 4'h1;
               end
            end
         end
         ST_KEY: begin
            if (slot_end) begin
               tmr_d = 6'h00;
               if (any_dig) begin
                  st_d = ST_DIGIT;
                  dig_d = first_dig[3:0];
               end else begin
                  irq_d = 1'b1;
               end
            end
         end
         default: st_d = ST_IDLE;
      endcase
      // a control write or a cleared enable restarts from idle
      if (!run || ctrl_wr) begin
         st_d = ST_IDLE;
         dig_d = 4'h0;
         tmr_d = 6'h00;
         irq_d = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= ST_IDLE;
         dig_q <= 4'h0;
         tmr_q <= 6'h00;
         irq_q <= 1'b0;
      end else begin
         st_q <= st_d;
         dig_q <= dig_d;
         tmr_q <= tmr_d;
         irq_q <= irq_d;
      end
   end

   // ****************************************************************
   // pin drive
   // ****************************************************************
   // pins follow the scan state one cycle later; invisible on a panel
   always_comb begin
      logic [15:0] grid;
      logic [23:0] anode;
      logic lit;
      grid = 16'h0000;
      anode = 24'h00_0000;
      lit = run && st_q == ST_DIGIT;
      if (lit) begin
         grid[dig_q] = 1'b1;
         if (boundary_q[`VFD_BIT_LAMP]) begin
            // segments beyond the range or lent to digits stay dark
            for (int s = 0; s < `VFD_SEGS; s++) begin
               anode[s] = ram_q[dig_q][s] && (s <= int'(segment_q[4:0])) &&
                  (s >= `VFD_SHARED_PINS ||
                   shared_anode(3'(7 - s), boundary_q[3:0]));
            end
         end
      end
      for (int k = 0; k < `VFD_SHARED_PINS; k++) begin
         role_d[k] = shared_anode(3'(k), boundary_q[3:0]);
         shared_d[k] = role_d[k] ? anode[7 - k] : grid[k];
      end
      grid_d = grid[15:8];
      anode_d = anode[23:8];
      // flag low or key scan slot hands the pins to the port logic
      port_d = !segment_q[`VFD_BIT_PFS] || st_q == ST_KEY;
      if (port_d) begin
         grid_d = '0;
         anode_d = '0;
         shared_d = 8'h00;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         grid_q <= '0;
         anode_q <= '0;
         shared_q <= 8'h00;
         role_q <= 8'h00;
         port_q <= 1'b1;
      end else begin
         grid_q <= grid_d;
         anode_q <= anode_d;
         shared_q <= shared_d;
         role_q <= role_d;
         port_q <= port_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign grid_pin = grid_q;
   assign anode_pin = anode_q;
   assign shared_pin = shared_q;
   assign shared_is_anode = role_q;
   assign port_mode = port_q;
   assign scan_irq_flag = irq_q;

endmodule // vfd_scan_ctrl

// ### vfd_panel_model.sv
// panel model: what the tube shows from the driver pins
// assumes pins are active high and shared pin k is digit k or segment 7-k
`timescale 1ns/1ps

module vfd_panel_model (
   // pins from the driver
   input wire logic [15:8] grid_pin,
   input wire logic [23:8] anode_pin,
   input wire logic [7:0] shared_pin,
   input wire logic [7:0] shared_is_anode,
   // what the panel lights
   output logic [15:0] grids,
   output logic [23:0] segs
);
   always_comb begin
      grids = {grid_pin, shared_pin & ~shared_is_anode};
      segs[23:8] = anode_pin;
      for (int s = 0; s < 8; s++) begin
         segs[s] = shared_pin[7-s] & shared_is_anode[7-s];
      end
   end
endmodule // vfd_panel_model

// ### vfd_scan_ctrl_props.sv
// checker for the scan controller ports
// assumes one clock domain, bound into every instance
`timescale 1ns/1ps

module vfd_scan_ctrl_props (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // pins
   input wire logic [15:8] grid_pin,
   input wire logic [23:8] anode_pin,
   input wire logic [7:0] shared_pin,
   input wire logic [7:0] shared_is_anode,
   input wire logic port_mode,
   input wire logic scan_irq_flag
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic [15:0] dg = {grid_pin, shared_pin & ~shared_is_anode};

   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("ready held");
   a_error_zero_data: assert property (pslverr |-> pready && prdata == 0)
      else $error("error with data");
   a_one_grid: assert property ($onehot0(dg))
      else $error("two grids lit");
   a_port_dark: assert property (port_mode |->
      shared_pin == 8'h00 && anode_pin == '0)
      else $error("pins lit in port mode");
   a_key_slot_ports: assert property (scan_irq_flag |=> port_mode [*8])
      else $error("key slot without ports");
   a_irq_one_pulse: assert property (scan_irq_flag |=> !scan_irq_flag)
      else $error("request held");
   a_split_form: assert property (
      (shared_is_anode & (shared_is_anode + 8'h01)) == 8'h00)
      else $error("bad pin split");
   a_lit_needs_grid: assert property (|anode_pin |-> |dg)
      else $error("segment lit without grid");

   // cover the main scenarios
   c_key: cover property (scan_irq_flag);
   c_err: cover property (pslverr);
   c_grid8: cover property ($rose(grid_pin[8]));
endmodule // vfd_scan_ctrl_props

bind vfd_scan_ctrl vfd_scan_ctrl_props i_vfd_scan_ctrl_props (.*);

// ### vfd_scan_ctrl_tb.sv
// self-checking bench for the scan controller
// assumes panel model and checker compiled first
`timescale 1ns/1ps
`include "vfd_defines.svh"

module vfd_scan_ctrl_tb;
   localparam logic [7:0] ob = `VFD_OFS_BOUNDARY;
   localparam logic [7:0] os = `VFD_OFS_SEGMENT;
   localparam logic [7:0] od = `VFD_OFS_DIGIT;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic port_mode, scan_irq_flag;
   logic [7:0] paddr, shared_pin, shared_is_anode;
   logic [31:0] pwdata, prdata, r;
   logic [3:0] pstrb;
   logic [15:8] grid_pin;
   logic [23:8] anode_pin;
   logic [15:0] grids;
   logic [23:0] segs;
   logic [31:0] ram [16];
   int err_count, comparisons, n, sp, rg;

   always #10 pclk = ~pclk;
   vfd_scan_ctrl i_vfd_scan_ctrl (.*);
   vfd_panel_model i_vfd_panel_model (.*);

   // *****
   // tasks
   // *****
   task automatic test_done;
      if (err_count == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      comparisons++;
      if (s !== x) begin
         err_count++;
         $display("unexpected at %0t: %h vs %h", $time, s, x);
      end
   endtask

   // hang guard: counts a mismatch and closes the run
   task automatic hang(inout int t);
      t++;
      if (t > 400) begin
         err_count++;
         test_done();
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      int t;
      t = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // answer taken at the edge where ready is seen, then released
      while (pready !== 1'b1) begin
         hang(t);
         @(posedge pclk);
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // g below zero waits for the key slot request
   task automatic wt(input int g);
      int t;
      t = 0;
      // pins lag a control write by two edges; skip the stale scan
      repeat (2) @(negedge pclk);
      while (g < 0 ? scan_irq_flag !== 1'b1 : grids !== 16'h1 << g) begin
         hang(t);
         @(negedge pclk);
      end
   endtask

   function automatic logic [31:0] xseg(int n, int rg, logic [31:0] w);
      logic [23:0] m;
      m = 24'hffffff >> (23 - (rg > 23 ? 23 : rg));
      m[7:0] = m[7:0] & (8'hff << (8 - n));
      return {8'h0, w[23:0] & m};
   endfunction

   // *****
   // main
   // *****
   initial begin
      {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = 0;
      pstrb = 4'hf;
      n = $urandom(11);
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, ob, 0);
      chk(r, 32'h20);
      apb(0, os, 0);
      chk(r, 32'h20);
      apb(1, ob, 32'h10);
      apb(0, ob, 0);
      chk(r, 32'h30);
      apb(1, ob, 32'h0);
      apb(0, ob, 0);
      chk(r, 32'h20);
      apb(0, 8'h20, 0);
      chk(32'(e), 32'h1);
      for (int d = 0; d < 16; d++) begin
         ram[d] = $urandom;
         apb(1, `VFD_RAM_BASE + 8'(4 * d), ram[d]);
      end
      for (int d = 0; d < 16; d++) begin
         apb(0, `VFD_RAM_BASE + 8'(4 * d), 0);
         chk(r, ram[d]);
      end
      apb(1, od, 0);
      for (int t = 0; t < 6; t++) begin
         n = t == 0 ? 8 : t == 2 ? 0 : $urandom % 9;
         rg = t == 1 ? 0 : $urandom % 32;
         sp = n == 8 ? 8 + $urandom % 8 : n;
         apb(1, os, 32'h80 | rg);
         apb(1, ob, 32'hc0 | sp);
         for (int g = n; g < n + 2; g++) begin
            wt(g);
            chk(32'(segs), xseg(n, rg, ram[g]));
            chk(32'(shared_is_anode), 32'hff >> (8 - n));
         end
      end
      // display off keeps the grids stepping
      apb(1, ob, 32'h80 | sp);
      wt(n + 1);
      chk(32'(segs), 0);
      apb(1, od, 32'h6);
      apb(1, os, 32'hd7);
      apb(1, ob, 32'hc8);
      wt(-1);
      @(negedge pclk);
      chk(32'(port_mode), 1);
      chk(32'(segs), 0);
      apb(0, os, 0);
      chk(r, 32'h77);
      wt(8);
      apb(1, ob, 32'h48);
      repeat (4) @(negedge pclk);
      chk(32'(grids), 0);
      chk(32'(port_mode), 0);
      apb(1, os, 32'h17);
      repeat (2) @(negedge pclk);
      chk(32'(port_mode), 1);
      test_done();
   end
endmodule // vfd_scan_ctrl_tb
